// ===== hdl/cserr_pkg.sv
package cserr_pkg;

   // ==========================================================================
   // bus geometry
   localparam int ADDR_W = 14;
   localparam int DATA_W = 32;
   localparam int PORTS = 4;
   localparam int MAP_W = 12;

   // ==========================================================================
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_UTP_STATUS = 12'h01c;
   localparam logic [11:0] IDX_MAP_ERR = 12'h01e;
   localparam logic [11:0] IDX_THR_EN = 12'h020;
   localparam logic [11:0] IDX_GLOBAL_STATUS = 12'h010;
   localparam logic [11:0] IDX_IRQ_MASK = 12'h011;

   // ==========================================================================
   // field positions
   localparam int UTP_RUN_LSB = 8;
   localparam int UTP_FAULT_LSB = 0;
   localparam int CAUSE_INVALID_BIT = 15;
   localparam int CAUSE_EMPTY_BIT = 14;
   localparam int CAUSE_REWRITE_BIT = 13;
   localparam int MAP_LSB = 0;
   localparam int GS_UTOPIA_BIT = 0;
   localparam int GS_MCAST_BIT = 1;

   // ==========================================================================
   // reset values and write masks
   localparam logic [3:0] RST_PORT = 4'h0;
   localparam logic [2:0] RST_CAUSE = 3'h0;
   localparam logic [11:0] RST_MAP = 12'h000;
   localparam logic [31:0] RST_THR_EN = 32'h0000_0000;
   localparam logic [31:0] THR_EN_WMASK = 32'hfe8b_5fdf;
   localparam logic [1:0] RST_GSTAT = 2'h0;
   localparam logic [1:0] RST_IMASK = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // byte address of a register index
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
      byte_addr = {idx, 2'b00};
   endfunction : byte_addr

   // ==========================================================================
   // whole state of the block
   typedef struct packed {
      logic [3:0] run_sync1;
      logic [3:0] run_sync2;
      logic [3:0] run_sync3;
      logic [3:0] run_live;
      logic [3:0] port_fault;
      logic drop_inhibit;
      logic [1:0] gstat;
      logic [1:0] imask;
      logic irq;
      logic [2:0] mc_cause;
      logic [11:0] mc_map;
      logic [31:0] thr_en;
      logic awready;
      logic wready;
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cserr_state_s;

endpackage : cserr_pkg

// ===== hdl/cserr_regs.sv
`timescale 1ns/1ps
module cserr_regs (
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   // axi4-lite write address
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [cserr_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic [2:0] S_AXI_AWPROT_I,
   // axi4-lite write data
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   // axi4-lite write response
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   output logic [1:0] S_AXI_BRESP_O,
   // axi4-lite read address
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   input wire logic [cserr_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic [2:0] S_AXI_ARPROT_I,
   // axi4-lite read data
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   // utopia port state, from the utopia clock domain
   input wire logic [3:0] PORT_RUNNING_I,
   // fifo crossing faults, system clock pulses, one bit per port
   input wire logic [3:0] FIFO_OVERRUN_I,
   input wire logic [3:0] FIFO_UNDERRUN_I,
   // multicast map error event, system clock pulse
   input wire logic MC_ERR_I,
   input wire logic MC_INVALID_TARGET_I,
   input wire logic MC_EMPTY_MAP_I,
   input wire logic MC_MAP_REWRITTEN_I,
   input wire logic [11:0] MC_BITMAP_I,
   // outputs to the rest of the switch
   output logic [31:0] THRESH_COUNT_ENABLE_O,
   output logic DROP_COUNT_INHIBIT_O,
   output logic IRQ_O
);

   // ==========================================================================
   // state
   cserr_pkg::cserr_state_s q;
   cserr_pkg::cserr_state_s next_q;
   logic [3:0] fifo_fault;
   logic wr_fire;
   logic [11:0] wr_idx;
   logic [11:0] rd_idx;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_hit;

   // byte-lane merge for writable registers
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      merge_bytes = res;
   endfunction : merge_bytes

   // ==========================================================================
   // next state
   always_comb begin
      next_q = q;
      // three-stage sampler; only stages two and three are compared
      next_q.run_sync1 = PORT_RUNNING_I;
      next_q.run_sync2 = q.run_sync1;
      next_q.run_sync3 = q.run_sync2;
      for (int p = 0; p < 4; p++) begin
         if (q.run_sync2[p] == q.run_sync3[p]) begin
            next_q.run_live[p] = q.run_sync3[p];
         end
      end

      // fifo crossing faults, sticky per port until reset
      fifo_fault = FIFO_OVERRUN_I | FIFO_UNDERRUN_I;
      next_q.port_fault = q.port_fault | fifo_fault;
      // tells the discard counters to skip this drop
      next_q.drop_inhibit = |fifo_fault;

      // write channel: address and data taken in either order
      if (S_AXI_AWVALID_I && q.awready) begin
         next_q.aw_held = 1'b1;
         next_q.aw_addr = S_AXI_AWADDR_I;
         next_q.awready = 1'b0;
      end
      if (S_AXI_WVALID_I && q.wready) begin
         next_q.w_held = 1'b1;
         next_q.w_data = S_AXI_WDATA_I;
         next_q.w_strb = S_AXI_WSTRB_I;
         next_q.wready = 1'b0;
      end
      wr_fire = q.aw_held && q.w_held && !q.bvalid;
      wr_idx = q.aw_addr[cserr_pkg::ADDR_W-1:2];
      wr_hit = q.aw_addr[1:0] == 2'b00 &&
               (wr_idx == cserr_pkg::IDX_UTP_STATUS || wr_idx == cserr_pkg::IDX_MAP_ERR ||
                wr_idx == cserr_pkg::IDX_THR_EN || wr_idx == cserr_pkg::IDX_GLOBAL_STATUS ||
                wr_idx == cserr_pkg::IDX_IRQ_MASK);

      // global status: software clear first, hardware set after so set wins
      if (wr_fire && wr_idx == cserr_pkg::IDX_GLOBAL_STATUS && q.w_strb[0]) begin
         next_q.gstat = q.gstat & ~q.w_data[1:0];
      end
      if (|fifo_fault) begin
         next_q.gstat[cserr_pkg::GS_UTOPIA_BIT] = 1'b1;
      end

      // multicast capture armed while the global bit is clear or being cleared
      if (MC_ERR_I) begin
         if (!next_q.gstat[cserr_pkg::GS_MCAST_BIT]) begin
            next_q.mc_cause = {MC_INVALID_TARGET_I, MC_EMPTY_MAP_I, MC_MAP_REWRITTEN_I};
            next_q.mc_map = MC_BITMAP_I;
         end
         next_q.gstat[cserr_pkg::GS_MCAST_BIT] = 1'b1;
      end

      // writable control registers; read-only ones ignore writes
      if (wr_fire && wr_idx == cserr_pkg::IDX_IRQ_MASK) begin
         next_q.imask = 2'(merge_bytes({30'h0, q.imask}, q.w_data, q.w_strb));
      end
      if (wr_fire && wr_idx == cserr_pkg::IDX_THR_EN) begin
         next_q.thr_en = merge_bytes(q.thr_en, q.w_data, q.w_strb) & cserr_pkg::THR_EN_WMASK;
      end

      // write response follows both halves
      if (wr_fire) begin
         next_q.bvalid = 1'b1;
         next_q.bresp = wr_hit ? cserr_pkg::RESP_OKAY : cserr_pkg::RESP_SLVERR;
         next_q.aw_held = 1'b0;
         next_q.w_held = 1'b0;
      end
      if (q.bvalid && S_AXI_BREADY_I) begin
         next_q.bvalid = 1'b0;
         next_q.awready = 1'b1;
         next_q.wready = 1'b1;
      end

      // read channel: one read at a time, answered the cycle after acceptance
      rd_idx = S_AXI_ARADDR_I[cserr_pkg::ADDR_W-1:2];
      rd_hit = 1'b1;
      rd_word = 32'h0000_0000;
      case (rd_idx)
         cserr_pkg::IDX_UTP_STATUS: begin
            rd_word[cserr_pkg::UTP_RUN_LSB +: 4] = q.run_live;
            rd_word[cserr_pkg::UTP_FAULT_LSB +: 4] = q.port_fault;
         end
         cserr_pkg::IDX_MAP_ERR: begin
            rd_word[cserr_pkg::CAUSE_INVALID_BIT] = q.mc_cause[2];
            rd_word[cserr_pkg::CAUSE_EMPTY_BIT] = q.mc_cause[1];
            rd_word[cserr_pkg::CAUSE_REWRITE_BIT] = q.mc_cause[0];
            rd_word[cserr_pkg::MAP_LSB +: 12] = q.mc_map;
         end
         cserr_pkg::IDX_THR_EN: begin
            rd_word = q.thr_en;
         end
         cserr_pkg::IDX_GLOBAL_STATUS: begin
            rd_word[1:0] = q.gstat;
         end
         cserr_pkg::IDX_IRQ_MASK: begin
            rd_word[1:0] = q.imask;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
      if (S_AXI_ARADDR_I[1:0] != 2'b00) begin
         rd_hit = 1'b0;
         rd_word = 32'h0000_0000;
      end
      if (S_AXI_ARVALID_I && q.arready) begin
         next_q.arready = 1'b0;
         next_q.rvalid = 1'b1;
         next_q.rdata = rd_word;
         next_q.rresp = rd_hit ? cserr_pkg::RESP_OKAY : cserr_pkg::RESP_SLVERR;
      end
      if (q.rvalid && S_AXI_RREADY_I) begin
         next_q.rvalid = 1'b0;
         next_q.arready = 1'b1;
      end

      // level interrupt from registered status and mask
      next_q.irq = |(next_q.gstat & next_q.imask);
   end

   // ==========================================================================
   // state register; reset loads constants only
   always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         q <= '0;
         q.run_live <= cserr_pkg::RST_PORT;
         q.port_fault <= cserr_pkg::RST_PORT;
         q.gstat <= cserr_pkg::RST_GSTAT;
         q.imask <= cserr_pkg::RST_IMASK;
         q.mc_cause <= cserr_pkg::RST_CAUSE;
         q.mc_map <= cserr_pkg::RST_MAP;
         q.thr_en <= cserr_pkg::RST_THR_EN;
         q.awready <= 1'b1;
         q.wready <= 1'b1;
         q.arready <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // ==========================================================================
   // outputs straight from the state register
   assign S_AXI_AWREADY_O = q.awready;
   assign S_AXI_WREADY_O = q.wready;
   assign S_AXI_BVALID_O = q.bvalid;
   assign S_AXI_BRESP_O = q.bresp;
   assign S_AXI_ARREADY_O = q.arready;
   assign S_AXI_RVALID_O = q.rvalid;
   assign S_AXI_RDATA_O = q.rdata;
   assign S_AXI_RRESP_O = q.rresp;
   assign THRESH_COUNT_ENABLE_O = q.thr_en;
   assign DROP_COUNT_INHIBIT_O = q.drop_inhibit;
   assign IRQ_O = q.irq;

endmodule : cserr_regs

// ===== verification/cserr_regs_sva.sv
`timescale 1ns/1ps
// ============================================================
// pin-level checks of the error and status bank
module cserr_regs_sva (
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   // bus handshakes
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WREADY_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic [31:0] S_AXI_RDATA_O,
   // fifo faults and drop inhibit
   input wire logic [3:0] FIFO_OVERRUN_I,
   input wire logic [3:0] FIFO_UNDERRUN_I,
   input wire logic DROP_COUNT_INHIBIT_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RESET_I);
   // any crossing fault this cycle
   wire logic flt = |(FIFO_OVERRUN_I | FIFO_UNDERRUN_I);
   // faulted cells must never reach the discard counters
   property p_drop_set; flt |=> DROP_COUNT_INHIBIT_O; endproperty
   property p_drop_clr; !flt |=> !DROP_COUNT_INHIBIT_O; endproperty
   // answers stand until taken
   property p_b_hold; S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O); endproperty
   property p_r_hold; S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O); endproperty
   // one transfer at a time
   property p_aw_ref; S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
   property p_r_ref; S_AXI_RVALID_O |-> !S_AXI_ARREADY_O; endproperty
   property p_b_done; S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O && S_AXI_AWREADY_O; endproperty
   property p_r_done; S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O && S_AXI_ARREADY_O; endproperty
   property p_r_cause; $rose(S_AXI_RVALID_O) |-> $past(S_AXI_ARVALID_I && S_AXI_ARREADY_O); endproperty
   a_drop_set: assert property (p_drop_set) else $error("drop inhibit missing");
   a_drop_clr: assert property (p_drop_clr) else $error("drop inhibit without fault");
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   a_aw_ref: assert property (p_aw_ref) else $error("write taken while response pending");
   a_r_ref: assert property (p_r_ref) else $error("read taken while data pending");
   a_b_done: assert property (p_b_done) else $error("write response not retired");
   a_r_done: assert property (p_r_done) else $error("read data not retired");
   a_r_cause: assert property (p_r_cause) else $error("read data without request");
   c_flt: cover property (flt);
   c_wr: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
   c_rd: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
endmodule : cserr_regs_sva

bind cserr_regs cserr_regs_sva u_sva (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I),
   .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
   .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
   .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
   .S_AXI_RDATA_O(S_AXI_RDATA_O), .FIFO_OVERRUN_I(FIFO_OVERRUN_I), .FIFO_UNDERRUN_I(FIFO_UNDERRUN_I),
   .DROP_COUNT_INHIBIT_O(DROP_COUNT_INHIBIT_O));

// ===== verification/cserr_regs_tb.sv
`timescale 1ns/1ps
// ============================================================
// self-checking bench of the error and status bank
module cserr_regs_tb;
   localparam logic [13:0] A_UTP = {cserr_pkg::IDX_UTP_STATUS, 2'h0};
   localparam logic [13:0] A_MAP = {cserr_pkg::IDX_MAP_ERR, 2'h0};
   localparam logic [13:0] A_THR = {cserr_pkg::IDX_THR_EN, 2'h0};
   localparam logic [13:0] A_GS = {cserr_pkg::IDX_GLOBAL_STATUS, 2'h0};
   localparam logic [13:0] A_IM = {cserr_pkg::IDX_IRQ_MASK, 2'h0};
   localparam logic [1:0] OK = cserr_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = cserr_pkg::RESP_SLVERR;
   logic clk, rst, awv, wv, br, arv, rr, mce, awr, wrdy, bv, arr, rv, drop, irq;
   logic [13:0] awa, ara;
   logic [3:0] prun, fov, fun;
   logic [2:0] mcc;
   logic [11:0] mcb;
   logic [1:0] bresp, rresp;
   logic [31:0] wd, rdat, thr, v;
   logic [15:0] seed;
   logic [3:0] run_exp;
   int fail_count, samples_checked, i;
   cserr_regs uut (.CORE_CLK_I(clk), .RESET_I(rst),
      .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa), .S_AXI_AWPROT_I(3'h0),
      .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf),
      .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bresp),
      .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara), .S_AXI_ARPROT_I(3'h0),
      .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp),
      .PORT_RUNNING_I(prun), .FIFO_OVERRUN_I(fov), .FIFO_UNDERRUN_I(fun), .MC_ERR_I(mce),
      .MC_INVALID_TARGET_I(mcc[2]), .MC_EMPTY_MAP_I(mcc[1]), .MC_MAP_REWRITTEN_I(mcc[0]),
      .MC_BITMAP_I(mcb), .THRESH_COUNT_ENABLE_O(thr), .DROP_COUNT_INHIBIT_O(drop), .IRQ_O(irq));
   // ============================================================
   // expectations and stimulus source
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [31:0] ust(input logic [3:0] r, input logic [3:0] f);
      return {20'h0, r, 4'h0, f};
   endfunction : ust
   function automatic logic [31:0] cap(input logic [2:0] c, input logic [11:0] m);
      return {16'h0, c, 1'h0, m};
   endfunction : cap
   // ============================================================
   // compare, bus and event tasks
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      awv <= 1'h1;
      awa <= a;
      wv <= 1'h1;
      wd <= d;
      br <= 1'h1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'h0;
         if (wrdy) wv <= 1'h0;
      end while (!bv && ++n < 64);
      br <= 1'h0;
      cmp("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : wr
   task automatic rd(input string nm, input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      arv <= 1'h1;
      ara <= a;
      rr <= 1'h1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'h0;
      end while (!rv && ++n < 64);
      rr <= 1'h0;
      cmp(nm, e, rdat);
      cmp("rresp", {30'h0, er}, {30'h0, rresp});
   endtask : rd
   task automatic ev(input logic [3:0] o, input logic [3:0] u, input logic m, input logic [2:0] c);
      @(posedge clk);
      fov <= o;
      fun <= u;
      mce <= m;
      mcc <= c;
      mcb <= seed[11:0] ^ {12{c == 3'h7}};
      @(posedge clk);
      fov <= 4'h0;
      fun <= 4'h0;
      mce <= 1'h0;
   endtask : ev
   task automatic results;
      if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results
   // clock at 40 MHz
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   // watchdog, far beyond the hundred and thirty or so cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end
   // ============================================================
   // main sequence
   initial begin
      {rst, awv, wv, br, arv, rr, mce, awa, ara, wd, prun, fov, fun, mcc, mcb} = '0;
      rst = 1'h1;
      seed = 16'h002f;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      rd("utp", A_UTP, 32'h0, OK);
      rd("map", A_MAP, 32'h0, OK);
      rd("unmapped", 14'h3ffc, 32'h0, ERR);
      // live running state, sampler needs four edges
      for (i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         prun <= seed[3:0];
         repeat (6) @(posedge clk);
         rd("run", A_UTP, ust(seed[3:0], 4'h0), OK);
      end
      // running bits stay at the last driven value for the flag checks
      run_exp = seed[3:0];
      seed = lfsr(seed);
      v = {seed, ~seed};
      wr(A_THR, v, OK);
      wr(14'h3ffc, ~v, ERR);
      rd("thr", A_THR, v & cserr_pkg::THR_EN_WMASK, OK);
      cmp("thr_out", v & cserr_pkg::THR_EN_WMASK, thr);
      // fifo faults: second one lands while the global bit is set
      wr(A_IM, 32'h1, OK);
      ev(4'h1, 4'h0, 1'h0, 3'h0);
      rd("gstat", A_GS, 32'h1, OK);
      cmp("irq", 32'h1, {31'h0, irq});
      ev(4'h0, 4'h4, 1'h0, 3'h0);
      rd("flags", A_UTP, ust(run_exp, 4'h5), OK);
      wr(A_UTP, 32'h0, OK);
      wr(A_GS, 32'h1, OK);
      rd("gstat", A_GS, 32'h0, OK);
      rd("flags", A_UTP, ust(run_exp, 4'h5), OK);
      cmp("irq", 32'h0, {31'h0, irq});
      // each cause, then a later error that must not overwrite
      wr(A_IM, 32'h3, OK);
      for (i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         ev(4'h0, 4'h0, 1'h1, 3'h4 >> i);
         ev(4'h0, 4'h0, 1'h1, 3'h7);
         rd("cap", A_MAP, cap(3'h4 >> i, seed[11:0]), OK);
         rd("gstat", A_GS, 32'h2, OK);
         cmp("irq", 32'h1, {31'h0, irq});
         wr(A_GS, 32'h2, OK);
      end
      results();
   end
endmodule : cserr_regs_tb
